// [rtl/cssel_defines.svh]
// offsets, field positions, codes and counts of the clock source and start-up selector
`ifndef CSSEL_DEFINES_SVH
`define CSSEL_DEFINES_SVH

// ==========================================================
// register byte offsets
`define CSSEL_OFF_TRIM 8'h00
`define CSSEL_OFF_PRESCALE 8'h04
`define CSSEL_OFF_STATUS 8'h08
`define CSSEL_OFF_CONTROL 8'h0C

// ==========================================================
// field positions
`define CSSEL_TRIM_RANGE_BIT 7
`define CSSEL_CTRL_SLEEP_BIT 0
`define CSSEL_STAT_RUN_BIT 0
`define CSSEL_STAT_SLEEP_BIT 1
`define CSSEL_STAT_HALT_BIT 2
`define CSSEL_STAT_SRC_LSB 8
`define CSSEL_STAT_STUP_LSB 12
`define CSSEL_STAT_OUTFUSE_BIT 14
`define CSSEL_STAT_DIV8_BIT 15

// ==========================================================
// fuse codes, 0 = programmed
`define CSSEL_SRC_EXT 4'h0
`define CSSEL_SRC_RC 4'h2
`define CSSEL_SRC_LF_FAST 4'h6
`define CSSEL_SRC_LF_SLOW 4'h7
`define CSSEL_STUP_NONE 2'h0
`define CSSEL_STUP_SHORT 2'h1
`define CSSEL_STUP_LONG 2'h2
`define CSSEL_FUSE_PROGRAMMED 1'h0

// ==========================================================
// reset values and counts
`define CSSEL_PS_DIV1 4'h0
`define CSSEL_PS_DIV8 4'h3
`define CSSEL_PS_MAX 4'h8
`define CSSEL_RST_CK 17'h0000E
`define CSSEL_WAKE_SHORT 17'h00006
`define CSSEL_WAKE_LF_FAST 17'h00400
`define CSSEL_WD_SHORT 17'h01000

`endif

// [rtl/cssel_pkg.sv]
// types of the clock source and start-up selector
package cssel_pkg;
    typedef enum logic [2:0] {
        ST_LATCH,
        ST_RST_WD,
        ST_RST_CK,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE,
        ST_HALT
    } cssel_state_t;
endpackage : cssel_pkg

// [rtl/cssel_top.sv]
// clock source selection, start-up timing, rc trim and clock output with an apb register port
//
// Overview of operation
// - fuse codes 0110 and 0111 select the low-frequency watch crystal.
// - crystal reset delay: 14 clocks plus 0, 4.1 ms or 65 ms; 11 reserved.
// - crystal wake from sleep takes 1K clocks (0110) or 32K clocks (0111).
// - fuse code 0010 selects the internal 8 MHz rc oscillator.
// - every reset loads the factory calibration byte into the trim register.
// - rc source wakes in 6 clocks; reset delay as start-up fuses say.
// - watchdog oscillator keeps timing the reset time-out whatever the source.
// - software may rewrite the 8-bit trim register, retuning the oscillator.
// - trim top bit picks lower or upper overlapping frequency range.
// - lower seven trim bits tune monotonically within the range.
// - fuse code 0000 selects the external clock on the oscillator input.
// - external clock wakes in 6 clocks; reset delay as start-up fuses say.
// - programmed clock output fuse drives system clock on the pin from reset release, through the start-up delay.
// - the clock output pin carries the prescaled system clock.
// - clock output works with every clock source.
// - programmed divide-by-eight fuse starts the prescaler at divide by 8.
// - 4.1 ms and 65 ms delays count 4,096 and 65,536 watchdog cycles.
// - every fuse bit reads 1 as unprogrammed and 0 as programmed.
`timescale 1ns/1ps
`include "cssel_defines.svh"

module cssel_top import cssel_pkg::*; #(
    parameter int WD_LONG = 65536,
    parameter int LF_WAKE_SLOW = 32768
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fuses and factory calibration
    input wire logic [3:0] clock_source_select_fuses,
    input wire logic [1:0] startup_time_fuses,
    input wire logic clock_output_fuse,
    input wire logic initial_divide_by_eight_fuse,
    input wire logic [7:0] factory_cal,
    // one-cycle edge ticks of each oscillator, and the wake request
    input wire logic lf_xtal_tick,
    input wire logic rc_osc_tick,
    input wire logic ext_clk_tick,
    input wire logic wd_osc_tick,
    input wire logic wake_req,
    // clock control outputs
    output logic [7:0] rc_oscillator_trim,
    output logic cpu_clk_en,
    output logic cpu_clk_tick,
    output logic watchdog_tick,
    output logic clock_output_pin,
    output logic clock_output_pin_oe
);

    // ==========================================================
    // state
    cssel_state_t state_ff, nxt_state;
    logic [16:0] cnt_ff, nxt_cnt;
    logic [3:0] srcsel_ff, nxt_srcsel;
    logic [1:0] stup_ff, nxt_stup;
    logic outfuse_ff, nxt_outfuse;
    logic div8_ff, nxt_div8;
    logic [7:0] trim_ff, nxt_trim;
    logic [3:0] ps_ff, nxt_ps;
    logic [7:0] pre_cnt_ff, nxt_pre_cnt;
    logic sysclk_ff, nxt_sysclk;
    logic run_tick_ff, nxt_run_tick;
    logic wd_ff, nxt_wd;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;

    logic src_tick;
    logic sys_tick;
    logic [16:0] wd_target;
    logic [16:0] wake_target;
    logic wr_en;
    logic sleep_wr;

    function automatic logic fuse_valid(input logic [3:0] ck, input logic [1:0] su);
        logic ok;
        ok = (ck == `CSSEL_SRC_EXT) || (ck == `CSSEL_SRC_RC) ||
             (ck == `CSSEL_SRC_LF_FAST) || (ck == `CSSEL_SRC_LF_SLOW);
        return ok && (su != 2'h3);
    endfunction : fuse_valid

    function automatic logic mapped(input logic [7:0] a);
        return (a == `CSSEL_OFF_TRIM) || (a == `CSSEL_OFF_PRESCALE) ||
               (a == `CSSEL_OFF_STATUS) || (a == `CSSEL_OFF_CONTROL);
    endfunction : mapped

    // ==========================================================
    // source selection and start-up targets
    always_comb begin
        unique case (srcsel_ff)
            `CSSEL_SRC_LF_FAST, `CSSEL_SRC_LF_SLOW: src_tick = lf_xtal_tick;
            `CSSEL_SRC_RC: src_tick = rc_osc_tick;
            `CSSEL_SRC_EXT: src_tick = ext_clk_tick;
            default: src_tick = 1'b0;
        endcase
        unique case (stup_ff)
            `CSSEL_STUP_SHORT: wd_target = `CSSEL_WD_SHORT;
            `CSSEL_STUP_LONG: wd_target = 17'(WD_LONG);
            default: wd_target = 17'h00000;
        endcase
        unique case (srcsel_ff)
            `CSSEL_SRC_LF_FAST: wake_target = `CSSEL_WAKE_LF_FAST;
            `CSSEL_SRC_LF_SLOW: wake_target = 17'(LF_WAKE_SLOW);
            default: wake_target = `CSSEL_WAKE_SHORT;
        endcase
    end

    // ==========================================================
    // apb decode
    assign wr_en = psel && penable && pready_ff && pwrite;
    assign sleep_wr = wr_en && (paddr == `CSSEL_OFF_CONTROL) && pwdata[`CSSEL_CTRL_SLEEP_BIT];

    // ==========================================================
    // start-up sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_srcsel = srcsel_ff;
        nxt_stup = stup_ff;
        nxt_outfuse = outfuse_ff;
        nxt_div8 = div8_ff;
        unique case (state_ff)
            ST_LATCH: begin
                // fuses are caught after release, since async reset may only load constants
                nxt_srcsel = clock_source_select_fuses;
                nxt_stup = startup_time_fuses;
                nxt_outfuse = clock_output_fuse;
                nxt_div8 = initial_divide_by_eight_fuse;
                nxt_cnt = 17'h00000;
                // reserved codes never release the clocks
                nxt_state = fuse_valid(clock_source_select_fuses, startup_time_fuses) ? ST_RST_WD : ST_HALT;
            end
            ST_RST_WD: begin
                if (cnt_ff >= wd_target) begin
                    nxt_state = ST_RST_CK;
                    nxt_cnt = 17'h00000;
                end else if (wd_osc_tick) begin
                    nxt_cnt = cnt_ff + 17'h00001;
                end
            end
            ST_RST_CK: begin
                if (cnt_ff >= `CSSEL_RST_CK) begin
                    nxt_state = ST_RUN;
                end else if (src_tick) begin
                    nxt_cnt = cnt_ff + 17'h00001;
                end
            end
            ST_RUN: begin
                if (sleep_wr) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_req) begin
                    nxt_state = ST_WAKE;
                    nxt_cnt = 17'h00000;
                end
            end
            ST_WAKE: begin
                if (cnt_ff >= wake_target) begin
                    nxt_state = ST_RUN;
                end else if (src_tick) begin
                    nxt_cnt = cnt_ff + 17'h00001;
                end
            end
            ST_HALT: begin
                nxt_state = ST_HALT;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_LATCH;
            cnt_ff <= 17'h00000;
            srcsel_ff <= 4'hF;
            stup_ff <= 2'h3;
            outfuse_ff <= 1'b1;
            div8_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            srcsel_ff <= nxt_srcsel;
            stup_ff <= nxt_stup;
            outfuse_ff <= nxt_outfuse;
            div8_ff <= nxt_div8;
        end
    end

    // ==========================================================
    // trim, prescaler and clock generation
    always_comb begin
        nxt_trim = trim_ff;
        nxt_ps = ps_ff;
        if (state_ff == ST_LATCH) begin
            nxt_trim = factory_cal;
            nxt_ps = (initial_divide_by_eight_fuse == `CSSEL_FUSE_PROGRAMMED) ? `CSSEL_PS_DIV8 : `CSSEL_PS_DIV1;
        end else if (wr_en && paddr == `CSSEL_OFF_TRIM) begin
            // range bit and fine bits go straight to the oscillator
            nxt_trim = pwdata[7:0];
        end else if (wr_en && paddr == `CSSEL_OFF_PRESCALE && pwdata[3:0] <= `CSSEL_PS_MAX) begin
            // reserved divide codes are ignored so the clock never stops
            nxt_ps = pwdata[3:0];
        end
        sys_tick = 1'b0;
        nxt_pre_cnt = pre_cnt_ff;
        if (src_tick) begin
            if (pre_cnt_ff >= 8'((9'h001 << ps_ff) - 9'h001)) begin
                sys_tick = 1'b1;
                nxt_pre_cnt = 8'h00;
            end else begin
                nxt_pre_cnt = pre_cnt_ff + 8'h01;
            end
        end
        // toggles on every divided edge, so the pin shows half the divided tick rate
        nxt_sysclk = sysclk_ff ^ sys_tick;
        nxt_run_tick = sys_tick && (state_ff == ST_RUN);
        nxt_wd = wd_osc_tick;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_ff <= 8'h00;
            ps_ff <= `CSSEL_PS_DIV8;
            pre_cnt_ff <= 8'h00;
            sysclk_ff <= 1'b0;
            run_tick_ff <= 1'b0;
            wd_ff <= 1'b0;
        end else begin
            trim_ff <= nxt_trim;
            ps_ff <= nxt_ps;
            pre_cnt_ff <= nxt_pre_cnt;
            sysclk_ff <= nxt_sysclk;
            run_tick_ff <= nxt_run_tick;
            wd_ff <= nxt_wd;
        end
    end

    // ==========================================================
    // apb answer: no wait state, data prepared in the setup cycle
    always_comb begin
        nxt_pready = psel && !penable;
        nxt_pslverr = psel && !penable && !mapped(paddr);
        nxt_prdata = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `CSSEL_OFF_TRIM: nxt_prdata = {24'h000000, trim_ff};
                `CSSEL_OFF_PRESCALE: nxt_prdata = {28'h0000000, ps_ff};
                `CSSEL_OFF_STATUS: begin
                    nxt_prdata[`CSSEL_STAT_RUN_BIT] = (state_ff == ST_RUN);
                    nxt_prdata[`CSSEL_STAT_SLEEP_BIT] = (state_ff == ST_SLEEP);
                    nxt_prdata[`CSSEL_STAT_HALT_BIT] = (state_ff == ST_HALT);
                    nxt_prdata[`CSSEL_STAT_SRC_LSB +: 4] = srcsel_ff;
                    nxt_prdata[`CSSEL_STAT_STUP_LSB +: 2] = stup_ff;
                    nxt_prdata[`CSSEL_STAT_OUTFUSE_BIT] = outfuse_ff;
                    nxt_prdata[`CSSEL_STAT_DIV8_BIT] = div8_ff;
                end
                default: nxt_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ==========================================================
    // outputs, each straight from a flip-flop
    logic cpu_en_ff;
    logic cko_oe_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_en_ff <= 1'b0;
            cko_oe_ff <= 1'b0;
        end else begin
            cpu_en_ff <= (nxt_state == ST_RUN);
            // the latched fuse owns the pin through every start-up state
            cko_oe_ff <= (nxt_outfuse == `CSSEL_FUSE_PROGRAMMED);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign rc_oscillator_trim = trim_ff;
    assign cpu_clk_en = cpu_en_ff;
    assign cpu_clk_tick = run_tick_ff;
    assign watchdog_tick = wd_ff;
    assign clock_output_pin = sysclk_ff;
    assign clock_output_pin_oe = cko_oe_ff;

    // ==========================================================
    // assertions
    a_trim_factory_load: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_LATCH |=> rc_oscillator_trim == $past(factory_cal))
        else $error("trim not loaded from factory calibration");
    a_trim_sw_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `CSSEL_OFF_TRIM && state_ff != ST_LATCH) |=> rc_oscillator_trim == $past(pwdata[7:0]))
        else $error("trim write lost");
    a_div8_start: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_LATCH && !initial_divide_by_eight_fuse) |=> ps_ff == 4'h3)
        else $error("prescaler not at divide by 8");
    a_rst_ck_count: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_RST_CK && $past(state_ff) == ST_RST_CK && nxt_state == ST_RUN) |-> cnt_ff == 17'h0000E)
        else $error("reset clock count is not 14");
    a_wd_delay_len: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_RST_WD && nxt_state == ST_RST_CK && stup_ff == 2'h1) |-> cnt_ff == 17'h01000)
        else $error("short time-out not 4096 watchdog cycles");
    a_wake_short: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_WAKE && srcsel_ff == 4'h2 && cnt_ff == 17'h00006) |=> state_ff == ST_RUN ##1 cpu_clk_en)
        else $error("rc wake not after 6 clocks");
    a_gate_until_done: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cpu_clk_en) |-> $past(state_ff, 2) inside {ST_RST_CK, ST_WAKE})
        else $error("cpu clock released early");
    a_clkout_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff != ST_LATCH && $past(state_ff) != ST_LATCH) |-> clock_output_pin_oe == !outfuse_ff)
        else $error("clock output enable disagrees with fuse");
    a_halt_gated: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_HALT |-> !cpu_clk_en && !cpu_clk_tick)
        else $error("clocks released on reserved fuses");

endmodule : cssel_top

// [tb/cssel_osc_model.sv]
// oscillator and clock source model that drives one-cycle edge ticks
`timescale 1ns/1ps

// ========
// free-running sources, each a fixed divide of pclk
module cssel_osc_model #(
    parameter int LF_P = 5,
    parameter int RC_P = 2,
    parameter int EXT_P = 3,
    parameter int WD_P = 3
) (
    // clock
    input wire logic pclk,
    // edge ticks
    output logic lf_xtal_tick,
    output logic rc_osc_tick,
    output logic ext_clk_tick,
    output logic wd_osc_tick
);
    int lf_ff = 0;
    int rc_ff = 0;
    int ext_ff = 0;
    int wd_ff = 0;

    // oscillators keep running through reset, as real ones do
    always @(posedge pclk) begin
        lf_ff <= (lf_ff + 1) % LF_P;
        rc_ff <= (rc_ff + 1) % RC_P;
        ext_ff <= (ext_ff + 1) % EXT_P;
        wd_ff <= (wd_ff + 1) % WD_P;
    end
    assign lf_xtal_tick = (lf_ff == 0);
    assign rc_osc_tick = (rc_ff == 0);
    // fixed period: no cycle-to-cycle frequency jump at all
    assign ext_clk_tick = (ext_ff == 0);
    assign wd_osc_tick = (wd_ff == 0);
endmodule : cssel_osc_model

// [tb/cssel_top_tb_top.sv]
// self-checking bench of the clock source and start-up selector
`timescale 1ns/1ps
`include "cssel_defines.svh"

module cssel_top_tb_top;
    logic pclk, presetn, psel, penable, pwrite, wake_req, co_f, d8_f, pready, pslverr;
    logic lf_t, rc_t, ext_t, wd_t, en, ctick, wtick, pin, pin_oe;
    logic [7:0] paddr, factory_cal, trim;
    logic [31:0] pwdata, prdata;
    logic [3:0] cs_f;
    logic [1:0] su_f;
    int error_cnt = 0;
    int total_checks = 0;
    int wd_bad = 0;
    logic pv_tick = 1'b0;
    logic pv_rst = 1'b0;

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    cssel_top #(.WD_LONG(64), .LF_WAKE_SLOW(40)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clock_source_select_fuses(cs_f), .startup_time_fuses(su_f), .clock_output_fuse(co_f),
        .initial_divide_by_eight_fuse(d8_f), .factory_cal(factory_cal), .lf_xtal_tick(lf_t), .rc_osc_tick(rc_t),
        .ext_clk_tick(ext_t), .wd_osc_tick(wd_t), .wake_req(wake_req), .rc_oscillator_trim(trim),
        .cpu_clk_en(en), .cpu_clk_tick(ctick), .watchdog_tick(wtick), .clock_output_pin(pin),
        .clock_output_pin_oe(pin_oe));

    cssel_osc_model osc (.pclk(pclk), .lf_xtal_tick(lf_t), .rc_osc_tick(rc_t), .ext_clk_tick(ext_t),
        .wd_osc_tick(wd_t));

    // ========
    // compare, verdict and bus tasks
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng

    task wrap_up;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // one idle cycle before each setup, so no signal is assigned twice in a step
    task apb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd,
             output logic err);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        // no wait-state count is assumed; the bench watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d, input logic xerr);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
        chk_val(e, xerr);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic xerr);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        chk_val(r, exp);
        chk_val(e, xerr);
    endtask : rd_chk

    // ========
    // one fuse setting: reset, start-up, registers, clock output, sleep and wake
    task run_cfg(input logic [3:0] cs, input logic [1:0] su, input logic co, input logic d8, input int ps,
                 input int wk);
        int cyc, tog, n_w, src, ct;
        logic hlt, pv;
        hlt = !(cs inside {4'h0, 4'h2, 4'h6, 4'h7}) || su == 2'h3;
        n_w = (su == 2'h0) ? 0 : ((su == 2'h1) ? 4096 : 64);
        @(posedge pclk);
        presetn <= 1'h0;
        cs_f <= cs;
        su_f <= su;
        co_f <= co;
        d8_f <= d8;
        factory_cal <= {cs, 2'h0, su} ^ 8'h5A;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        cyc = 0;
        tog = 0;
        pv = 1'b0;
        while (en !== 1'b1 && cyc < (hlt ? 300 : 20000)) begin
            @(posedge pclk);
            cyc++;
            if (pin !== pv) tog++;
            pv = pin;
        end
        chk_val(pin_oe, !co);
        if (co == 1'b0) chk_rng(tog, 1, cyc);
        if (hlt) begin
            chk_val(en, 1'b0);
            rd_chk(`CSSEL_OFF_STATUS, {16'h0, d8, co, su, cs, 8'h04}, 1'b0);
        end else begin
            chk_rng(cyc, n_w * 3 + 14 * ps - ps - 3, n_w * 3 + 14 * ps + ps + 12);
            rd_chk(`CSSEL_OFF_STATUS, {16'h0, d8, co, su, cs, 8'h01}, 1'b0);
            rd_chk(`CSSEL_OFF_TRIM, {24'h0, factory_cal}, 1'b0);
            rd_chk(`CSSEL_OFF_PRESCALE, d8 ? 32'h0 : 32'h3, 1'b0);
            wr(`CSSEL_OFF_PRESCALE, 32'h1, 1'b0);
            wr(`CSSEL_OFF_PRESCALE, 32'h9, 1'b0);
            rd_chk(`CSSEL_OFF_PRESCALE, 32'h1, 1'b0);
            src = 0;
            tog = 0;
            ct = 0;
            pv = pin;
            repeat (40 * ps) begin
                @(posedge pclk);
                src += int'(cs == 4'h0 ? ext_t : (cs == 4'h2 ? rc_t : lf_t));
                ct += int'(ctick);
                if (pin !== pv) tog++;
                pv = pin;
            end
            chk_rng(tog, src / 2 - 2, src / 2 + 2);
            chk_rng(ct, src / 2 - 2, src / 2 + 2);
            wr(`CSSEL_OFF_CONTROL, 32'h1, 1'b0);
            repeat (2) @(posedge pclk);
            chk_val(en, 1'b0);
            rd_chk(`CSSEL_OFF_STATUS, {16'h0, d8, co, su, cs, 8'h02}, 1'b0);
            @(posedge pclk);
            wake_req <= 1'h1;
            @(posedge pclk);
            wake_req <= 1'h0;
            cyc = 0;
            while (en !== 1'b1 && cyc < 20000) begin
                @(posedge pclk);
                cyc++;
            end
            chk_rng(cyc, wk * ps - ps, wk * ps + ps + 6);
        end
    endtask : run_cfg

    // watchdog tick must follow its oscillator by one cycle whatever the source
    always @(posedge pclk) begin
        if (presetn === 1'b1 && pv_rst === 1'b1 && wtick !== pv_tick) wd_bad <= wd_bad + 1;
        pv_tick <= wd_t;
        pv_rst <= presetn;
    end

    initial begin
        #4000000;
        error_cnt++;
        wrap_up();
    end

    // ========
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wake_req = 1'b0;
        cs_f = 4'hF;
        su_f = 2'h3;
        co_f = 1'b1;
        d8_f = 1'b1;
        factory_cal = 8'h00;
        run_cfg(4'h2, 2'h2, 1'b0, 1'b0, 2, 6);
        // the two trims sit on the range boundary: top of the lower range, then bottom of the upper range
        wr(`CSSEL_OFF_TRIM, 32'h7F, 1'b0);
        rd_chk(`CSSEL_OFF_TRIM, 32'h7F, 1'b0);
        chk_val(trim, 8'h7F);
        wr(`CSSEL_OFF_TRIM, 32'h80, 1'b0);
        rd_chk(`CSSEL_OFF_TRIM, 32'h80, 1'b0);
        chk_val(trim, 8'h80);
        wr(8'h10, 32'hFF, 1'b1);
        rd_chk(8'h10, 32'h0, 1'b1);
        run_cfg(4'h0, 2'h0, 1'b0, 1'b1, 3, 6);
        run_cfg(4'h6, 2'h1, 1'b1, 1'b1, 5, 1024);
        run_cfg(4'h7, 2'h2, 1'b0, 1'b0, 5, 40);
        run_cfg(4'h3, 2'h0, 1'b1, 1'b1, 2, 6);
        run_cfg(4'h2, 2'h3, 1'b1, 1'b1, 2, 6);
        chk_val(wd_bad, 32'h0);
        wrap_up();
    end
endmodule : cssel_top_tb_top
